// [pkg/acc_params.svh]
// Register indices, field positions, DIDR reset value and codes of the comparator control
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_IDX_DIDR   8'h01
`define ACC_IDX_CTRLB  8'h03
`define ACC_IDX_STAT   8'h08
`define ACC_IDX_MASK   8'h06
`define ACC_B_DIS      7
`define ACC_B_BG       6
`define ACC_B_RES      5
`define ACC_B_FLAG     4
`define ACC_B_IE       3
`define ACC_B_CAP      2
`define ACC_B_ES_HI    1
`define ACC_B_ES_LO    0
`define ACC_B_MUXEN    6
`define ACC_B_GIE      4
`define ACC_B_BUF2     2
`define ACC_B_BUF1     1
`define ACC_DIDR_RST   8'h00
`define ACC_ES_TOGGLE  2'h0
`define ACC_ES_RSVD    2'h1
`define ACC_ES_FALL    2'h2
`define ACC_ES_RISE    2'h3
`define ACC_CH_LOW     2'h0
`endif

// [pkg/acc_pkg.sv]
// State types of the comparator control modules
package acc_pkg;
   `include "acc_params.svh"

   typedef struct packed {
      logic [7:0]  didr;
      logic        dis;
      logic        bg;
      logic        flag;
      logic        ie;
      logic        cap;
      logic [1:0]  es;
      logic        muxen;
      logic        gie;
      logic        neg_pin;
      logic [2:0]  neg_ch;
      logic        cap_out;
      logic [1:0]  pin_rd;
      logic        irq;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } acc_top_st_t;

   typedef struct packed {
      logic s1;
      logic s2;
   } acc_sync_st_t;

   typedef struct packed {
      logic prev;
      logic primed;
   } acc_edge_st_t;
endpackage

// [pkg/acc_evt_if.sv]
// Comparator sample path between synchroniser, edge detector and control
`timescale 1ns/1ns
interface acc_evt_if;
   logic cmp_raw;
   logic cmp_sync;
   logic rise;
   logic fall;
   logic toggle;

   modport syncr (input cmp_raw, output cmp_sync);
   modport edger (input cmp_sync, output rise, output fall, output toggle);
   modport ctrl  (output cmp_raw, input cmp_sync, input rise, input fall, input toggle);
endinterface

// [core/acc_sync.sv]
// Two-stage synchroniser for the free-running comparator output
`timescale 1ns/1ns
module acc_sync (
   // Clock and reset
   input  logic     pclk,
   input  logic     presetn,
   // Sample path
   acc_evt_if.syncr ev
);
   import acc_pkg::*;

   acc_sync_st_t st, nx;

   // First stage feeds only the second
   always_comb begin
      nx    = st;
      nx.s1 = ev.cmp_raw;
      nx.s2 = st.s1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign ev.cmp_sync = st.s2;
endmodule

// [core/acc_edge.sv]
// Rise, fall and toggle pulses of the synchronised comparator output
`timescale 1ns/1ns
module acc_edge (
   // Clock and reset
   input  logic     pclk,
   input  logic     presetn,
   // Sample path
   acc_evt_if.edger ev
);
   import acc_pkg::*;

   acc_edge_st_t st, nx;

   // No event on the first sample, reset value is not a real level
   always_comb begin
      nx        = st;
      nx.prev   = ev.cmp_sync;
      nx.primed = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign ev.rise   = st.primed & ev.cmp_sync & ~st.prev;
   assign ev.fall   = st.primed & ~ev.cmp_sync & st.prev;
   assign ev.toggle = st.primed & (ev.cmp_sync ^ st.prev);
endmodule

// [core/acc_top.sv]
// Analog comparator control with APB registers, event flag and input routing
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`include "acc_params.svh"
module acc_top #(
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input  logic              pclk,
   input  logic              presetn,
   // APB slave
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [ADDR_W-1:0] paddr,
   input  logic [31:0]       pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   // Analog comparator
   input  logic              cmp_raw,
   output logic              comparator_power_off,
   output logic              bandgap_select,
   output logic              negative_pin_select,
   output logic [2:0]        negative_channel,
   // Converter state
   input  logic              converter_enable,
   input  logic [4:0]        converter_channel_select,
   // Interrupt
   input  logic              irq_ack,
   output logic              comparator_irq,
   // Timer capture
   output logic              capture_input,
   // Pin buffers, bit 0 positive pin, bit 1 negative pin; input_buffer_off bit 1 positive pin, bit 2 negative pin
   input  logic [1:0]        pin_raw,
   output logic [1:0]        pin_read,
   output logic [7:0]        input_buffer_off
);
   import acc_pkg::*;

   acc_top_st_t st, nx;
   acc_evt_if   ev ();

   logic [ADDR_W-3:0] idx;
   logic              setup;
   logic              wr_en;
   logic              hit;
   logic              wr_stat;
   logic              ev_hit;
   logic              mux_pick;

   assign ev.cmp_raw = cmp_raw;

   acc_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (ev.syncr)
   );

   acc_edge u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (ev.edger)
   );

   assign idx   = paddr[ADDR_W-1:2];
   assign hit   = (paddr[1:0] == 2'h0) &&
                  (idx == `ACC_IDX_DIDR || idx == `ACC_IDX_CTRLB ||
                   idx == `ACC_IDX_STAT || idx == `ACC_IDX_MASK);
   assign setup = psel & ~penable;
   // Write lands only at the completing edge
   assign wr_en   = psel & penable & pready & pwrite & hit;
   assign wr_stat = wr_en && (idx == `ACC_IDX_STAT);

   always_comb begin
      unique case (st.es)
         `ACC_ES_TOGGLE: ev_hit = ev.toggle;
         `ACC_ES_RSVD:   ev_hit = 1'b0;
         `ACC_ES_FALL:   ev_hit = ev.fall;
         `ACC_ES_RISE:   ev_hit = ev.rise;
      endcase
   end

   // mux path only for converter off
   assign mux_pick = st.muxen && !converter_enable &&
                     (converter_channel_select[4:3] == `ACC_CH_LOW);

   function automatic logic [31:0] rd_word(input logic [ADDR_W-3:0] i,
                                           input acc_top_st_t s,
                                           input logic res);
      logic [31:0] w;
      w = '0;
      if (i == `ACC_IDX_DIDR) begin
         w[7:0] = s.didr;
      end else if (i == `ACC_IDX_CTRLB) begin
         w[`ACC_B_MUXEN] = s.muxen;
      end else if (i == `ACC_IDX_MASK) begin
         w[`ACC_B_GIE] = s.gie;
      end else if (i == `ACC_IDX_STAT) begin
         w[`ACC_B_DIS]   = s.dis;
         w[`ACC_B_BG]    = s.bg;
         w[`ACC_B_RES]   = res;
         w[`ACC_B_FLAG]  = s.flag;
         w[`ACC_B_IE]    = s.ie;
         w[`ACC_B_CAP]   = s.cap;
         w[`ACC_B_ES_HI] = s.es[1];
         w[`ACC_B_ES_LO] = s.es[0];
      end
      return w;
   endfunction

   always_comb begin
      nx         = st;
      nx.pready  = 1'b0;
      nx.pslverr = 1'b0;
      // Answer prepared in setup so pready comes from a flop, no wait state
      if (setup) begin
         nx.pready  = 1'b1;
         nx.pslverr = ~hit;
         nx.prdata  = hit ? rd_word(idx, st, ev.cmp_sync) : '0;
      end
      if (wr_en && idx == `ACC_IDX_DIDR) begin
         nx.didr = pwdata[7:0];
      end
      if (wr_en && idx == `ACC_IDX_CTRLB) begin
         nx.muxen = pwdata[`ACC_B_MUXEN];
      end
      if (wr_en && idx == `ACC_IDX_MASK) begin
         nx.gie = pwdata[`ACC_B_GIE];
      end
      if (wr_stat) begin
         nx.dis = pwdata[`ACC_B_DIS];
         nx.bg  = pwdata[`ACC_B_BG];
         nx.ie  = pwdata[`ACC_B_IE];
         nx.cap = pwdata[`ACC_B_CAP];
         nx.es  = {pwdata[`ACC_B_ES_HI], pwdata[`ACC_B_ES_LO]};
      end
      if (irq_ack || (wr_stat && pwdata[`ACC_B_FLAG])) begin
         nx.flag = 1'b0;
      end
      // event sets flag, set beats clear
      if (ev_hit) begin
         nx.flag = 1'b1;
      end
      nx.irq     = st.flag & st.ie & st.gie;
      nx.neg_pin = ~mux_pick;
      nx.neg_ch  = mux_pick ? converter_channel_select[2:0] : st.neg_ch;
      nx.cap_out = st.cap & ev.cmp_sync;
      nx.pin_rd  = pin_raw & ~{st.didr[`ACC_B_BUF2], st.didr[`ACC_B_BUF1]};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st      <= '0;
         st.didr <= `ACC_DIDR_RST;
         st.neg_pin <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign prdata               = st.prdata;
   assign pready               = st.pready;
   assign pslverr              = st.pslverr;
   assign comparator_power_off = st.dis;
   assign bandgap_select       = st.bg;
   assign negative_pin_select  = st.neg_pin;
   assign negative_channel     = st.neg_ch;
   assign comparator_irq       = st.irq;
   assign capture_input        = st.cap_out;
   assign pin_read             = st.pin_rd;
   assign input_buffer_off     = st.didr;

   // Checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_stat_wr;
      wr_stat;
   endsequence

   sequence s_match;
      (st.es == `ACC_ES_TOGGLE && ev.toggle) ||
      (st.es == `ACC_ES_FALL && ev.fall) ||
      (st.es == `ACC_ES_RISE && ev.rise);
   endsequence

   a_result_sync: assert property (cmp_raw [*3] |-> ev.cmp_sync)
      else $error("result not synchronised within two cycles");

   a_neg_pin_sel: assert property ((!st.muxen || converter_enable) |=>
         negative_pin_select)
      else $error("dedicated negative pin not selected");

   a_neg_channel: assert property (mux_pick |=>
         !negative_pin_select && negative_channel == $past(converter_channel_select[2:0]))
      else $error("negative channel not taken from converter code");

   a_power_off: assert property (s_stat_wr ##0 pwdata[`ACC_B_DIS] |=>
         comparator_power_off)
      else $error("comparator power not switched off");

   a_bandgap_sel: assert property (s_stat_wr |=>
         bandgap_select == $past(pwdata[`ACC_B_BG]))
      else $error("bandgap select not written");

   a_flag_set: assert property (s_match |=> st.flag)
      else $error("matching event did not set flag");

   a_flag_clear: assert property ((irq_ack && !ev_hit) |=> !st.flag)
      else $error("flag not cleared by vector");

   a_flag_keep: assert property ((s_stat_wr ##0 !pwdata[`ACC_B_FLAG] && !irq_ack && st.flag)
         |=> st.flag)
      else $error("writing zero changed flag");

   a_irq_gate: assert property ((st.flag && st.ie && st.gie) |=> comparator_irq)
      else $error("interrupt not requested");

   a_irq_off: assert property (!(st.flag && st.ie && st.gie) |=> !comparator_irq)
      else $error("interrupt requested without all enables");

   a_capture_off: assert property (!st.cap |=> !capture_input)
      else $error("capture input driven while routing off");

   a_reserved_mode: assert property ((st.es == `ACC_ES_RSVD && !st.flag) |=> !st.flag)
      else $error("reserved event mode set flag");

   a_pin_read_zero: assert property (st.didr[`ACC_B_BUF1] |=> !pin_read[0])
      else $error("disabled pin did not read zero");

   a_rise_pulse: assert property (($rose(ev.cmp_sync) && $past(presetn, 2)) |->
         ev.rise)
      else $error("rise pulse missing");

   a_result_low: assert property (!cmp_raw [*3] |-> !ev.cmp_sync)
      else $error("result not cleared within two cycles");

   a_result_read: assert property ((setup && hit && idx == `ACC_IDX_STAT) |=>
         prdata[`ACC_B_RES] == $past(ev.cmp_sync))
      else $error("result bit not returned on read");

   a_neg_code_high: assert property (
         (converter_channel_select[4:3] != `ACC_CH_LOW) |=> negative_pin_select)
      else $error("high channel code did not select negative pin");

   a_neg_hold: assert property (!mux_pick |=> $stable(negative_channel))
      else $error("negative channel changed while pin selected");

   a_power_on: assert property (s_stat_wr ##0 !pwdata[`ACC_B_DIS] |=>
         !comparator_power_off)
      else $error("comparator power not switched on");

   a_power_hold: assert property (!wr_stat |=> $stable(comparator_power_off))
      else $error("comparator power changed without write");

   a_bandgap_hold: assert property (!wr_stat |=> $stable(bandgap_select))
      else $error("bandgap select changed without write");

   a_flag_set_wins: assert property ((ev_hit && (irq_ack || wr_stat)) |=> st.flag)
      else $error("clear beat a matching event");

   a_flag_idle: assert property ((!st.flag && !ev_hit) |=> !st.flag)
      else $error("flag set without matching event");

   a_flag_w1c: assert property ((wr_stat && pwdata[`ACC_B_FLAG] && !ev_hit) |=>
         !st.flag)
      else $error("writing one did not clear flag");

   a_capture_on: assert property (st.cap |=> capture_input == $past(ev.cmp_sync))
      else $error("capture input does not follow result");

   a_fall_only: assert property ((st.es == `ACC_ES_FALL && ev.rise && !st.flag) |=>
         !st.flag)
      else $error("rising edge set flag in falling mode");

   a_rise_only: assert property ((st.es == `ACC_ES_RISE && ev.fall && !st.flag) |=>
         !st.flag)
      else $error("falling edge set flag in rising mode");

   a_pin_neg_zero: assert property (st.didr[`ACC_B_BUF2] |=> !pin_read[1])
      else $error("disabled negative pin did not read zero");

   a_pin_pass: assert property (!st.didr[`ACC_B_BUF1] |=>
         pin_read[0] == $past(pin_raw[0]))
      else $error("enabled positive pin not passed through");

   a_fall_pulse: assert property (($fell(ev.cmp_sync) && $past(presetn, 2)) |->
         ev.fall)
      else $error("fall pulse missing");

   a_no_edge: assert property ($stable(ev.cmp_sync) |-> !ev.toggle)
      else $error("toggle pulse without change");
endmodule

// [sim/test_analog_comparator_control.sv]
// Self-checking testbench of the comparator control block
`timescale 1ns/1ns
`include "acc_params.svh"
module test_analog_comparator_control;
   logic        pclk, presetn, psel, penable, pwrite, cmp_raw, cv_en, irq_ack;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, pwr_off, bg_sel, npin, cap_in, irq, err;
   logic [2:0]  nch;
   logic [4:0]  ch_sel;
   logic [1:0]  pin_raw, pin_read;
   logic [7:0]  buf_off;
   int          n_errors, checks_done;

   acc_top #(.ADDR_W(10)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_raw(cmp_raw), .comparator_power_off(pwr_off), .bandgap_select(bg_sel),
      .negative_pin_select(npin), .negative_channel(nch), .converter_enable(cv_en),
      .converter_channel_select(ch_sel), .irq_ack(irq_ack), .comparator_irq(irq),
      .capture_input(cap_in), .pin_raw(pin_raw), .pin_read(pin_read),
      .input_buffer_off(buf_off));

   always #4 pclk = ~pclk;

   task conclude;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Master holds the request until pready is seen high at an edge
   task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_errors++;
         $display("[ERR] %0t no bus answer", $time);
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wreg(input logic [7:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask

   task rreg(input logic [7:0] idx);
      apb(1'b0, idx, 32'h0);
   endtask

   task t_reset;
      chk(npin, 1, "pin select");
      chk({pwr_off, bg_sel, irq, cap_in}, 0, "outputs");
      rreg(`ACC_IDX_DIDR);
      chk(rd, 32'h0, "didr reset");
      rreg(`ACC_IDX_STAT);
      chk(rd, 32'h0, "ctrl reset");
      rreg(`ACC_IDX_CTRLB);
      chk(rd, 32'h0, "ctrlb reset");
      rreg(8'h02);
      chk(rd, 32'h0, "unmapped data");
      chk(err, 1, "unmapped error");
      $display("reset test done");
   endtask

   task t_ctrl;
      wreg(`ACC_IDX_STAT, 32'hc0);
      tick(2);
      chk({pwr_off, bg_sel}, 2'h3, "power bg");
      wreg(`ACC_IDX_STAT, 32'h40);
      tick(2);
      chk({pwr_off, bg_sel}, 2'h1, "bandgap only");
      wreg(`ACC_IDX_STAT, 32'h20);
      tick(2);
      chk({pwr_off, bg_sel}, 0, "power bg");
      rreg(`ACC_IDX_STAT);
      chk(rd, 32'h0, "result read only");
      pin_raw <= 2'h3;
      wreg(`ACC_IDX_DIDR, 32'h02);
      tick(2);
      chk({buf_off, pin_read}, {8'h02, 2'h2}, "buffer 1");
      wreg(`ACC_IDX_DIDR, 32'h04);
      tick(2);
      chk({buf_off, pin_read}, {8'h04, 2'h1}, "buffer 2");
      wreg(`ACC_IDX_DIDR, 32'h00);
      tick(2);
      chk(pin_read, 2'h3, "buffers on");
      $display("control test done");
   endtask

   task t_mux;
      wreg(`ACC_IDX_CTRLB, 32'h40);
      for (int c = 0; c < 8; c++) begin
         ch_sel <= 5'(c);
         tick(3);
         chk({npin, nch}, 4'(c), "channel");
      end
      ch_sel <= 5'h08;
      tick(3);
      chk(npin, 1, "code above 7");
      ch_sel <= 5'h02;
      cv_en <= 1'b1;
      tick(3);
      chk(npin, 1, "converter on");
      cv_en <= 1'b0;
      wreg(`ACC_IDX_CTRLB, 32'h00);
      tick(3);
      chk(npin, 1, "mux off");
      $display("mux test done");
   endtask

   // Interrupt enable stays clear while the event select changes
   task t_events;
      logic er, ef;
      for (int es = 0; es < 4; es++) begin
         er = (es == 0 || es == 3);
         ef = (es == 0 || es == 2);
         wreg(`ACC_IDX_STAT, 32'h14 | es);
         cmp_raw <= 1'b1;
         tick(1);
         chk(cap_in, 0, "sync delay");
         tick(5);
         chk(cap_in, 1, "capture route");
         rreg(`ACC_IDX_STAT);
         chk(rd[5:4], {1'b1, er}, "rise event");
         wreg(`ACC_IDX_STAT, 32'h10 | es);
         rreg(`ACC_IDX_STAT);
         chk(rd[4], 0, "flag clear");
         cmp_raw <= 1'b0;
         tick(6);
         rreg(`ACC_IDX_STAT);
         chk(rd[5:4], {1'b0, ef}, "fall event");
         cmp_raw <= 1'b1;
         tick(6);
         chk(cap_in, 0, "capture off");
         cmp_raw <= 1'b0;
         tick(6);
      end
      $display("event test done");
   endtask

   task t_irq;
      wreg(`ACC_IDX_STAT, 32'h13);
      wreg(`ACC_IDX_STAT, 32'h0b);
      cmp_raw <= 1'b1;
      tick(6);
      chk(irq, 0, "global off");
      wreg(`ACC_IDX_MASK, 32'h10);
      tick(3);
      chk(irq, 1, "irq on");
      wreg(`ACC_IDX_STAT, 32'h0b);
      tick(3);
      chk(irq, 1, "zero write");
      irq_ack <= 1'b1;
      tick(1);
      irq_ack <= 1'b0;
      tick(3);
      chk(irq, 0, "vector clear");
      rreg(`ACC_IDX_STAT);
      chk(rd, 32'h2b, "flag after ack");
      $display("interrupt test done");
   endtask

   initial begin
      {pclk, presetn, psel, penable, pwrite, cmp_raw, cv_en, irq_ack} = 0;
      paddr = 0;
      pwdata = 0;
      ch_sel = 0;
      pin_raw = 0;
      n_errors = 0;
      checks_done = 0;
      tick(4);
      presetn <= 1'b1;
      t_reset();
      t_ctrl();
      t_mux();
      t_events();
      t_irq();
      conclude();
   end
endmodule
